// file: src/mpos_pkg.sv
// Constants for the multi-position run sequencer.
// Assumes one clock domain and no register bus.
package mpos_pkg;
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_CYCLIC = 2'h1;
    localparam logic [1:0] MODE_DI = 2'h2;
    localparam logic [1:0] MODE_SEQ = 2'h3;
    localparam logic MARGIN_FINISH = 1'h0;
    localparam logic MARGIN_RESTART = 1'h1;
    localparam int POS_W = 4;
    localparam int WAIT_W = 16;
    localparam logic [POS_W-1:0] FIRST_POS = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_WAIT = 3'b010,
        ST_PAUSE = 3'b011,
        ST_SOFF = 3'b100
    } seq_state_t;
endpackage

// file: src/multi_position_sequencer.sv
// Multi-position run sequencer: cyclic running and DI switchover.
// Assumes the motion loop reports move done and stop done on mclk.
//
// Contract
// R1 - Mode 1 restarts at position one cyclically
// R2 - Completion flag after each finished position
// R3 - Enable drop discards remainder and stops (done in mode 1 only; in mode 2 the move runs on to done)
// R4 - Completion flag after enable-drop stop ends
// R5 - Resume per margin method on re-enable
// R6 - Servo-off stops using selected stop mode
// R7 - Completion flag low after servo-off stop
// R8 - Direction sampled only at position start
// R9 - Mode 2 takes position from DI levels
// R10 - DI switchover decodes position from terminals
// R11 - Controller holds enable steady during run
// R12 - Cyclic modes advance to next position (mode 1 only; MODE_SEQ never starts a run)
// R13 - Wait time inserted between cyclic positions
// R14 - DI switchover keeps running on update
`timescale 1ns/1ps
module multi_position_sequencer
    import mpos_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Terminal inputs, asynchronous
    input wire logic multiPositionEnable,
    input wire logic servoOn,
    input wire logic directionSelect,
    input wire logic [POS_W-1:0] diPosition,
    // Settings
    input wire logic [1:0] runModeSelect,
    input wire logic marginMethod,
    input wire logic [1:0] stopModeSelect,
    input wire logic [POS_W-1:0] positionCountSetting,
    input wire logic [WAIT_W-1:0] waitCycles,
    // Motion loop feedback
    input wire logic moveDone,
    input wire logic stopDone,
    // Motion loop commands
    output logic posStart,
    output logic [POS_W-1:0] posNumber,
    output logic posDirection,
    output logic stopRequest,
    output logic discardRemainder,
    output logic [1:0] stopMode,
    output logic positioningComplete
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [POS_W+2:0] syncA_r, syncB_r;
    logic enS, sonS, dirS;
    logic [POS_W-1:0] diS;
    logic [POS_W-1:0] diPrev_r;
    logic diSteady;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_r <= '0;
            syncB_r <= '0;
            diPrev_r <= '0;
        end else begin
            syncA_r <= {multiPositionEnable, servoOn, directionSelect,
                        diPosition};
            syncB_r <= syncA_r;
            diPrev_r <= diS;
        end
    end
    assign {enS, sonS, dirS, diS} = syncB_r;
    // Bits of a terminal word may land an edge apart: act on two equal samples
    assign diSteady = (diS == diPrev_r);

    function automatic logic [POS_W-1:0] nextPos(
        input logic [POS_W-1:0] p, input logic [POS_W-1:0] cnt);
        nextPos = (p + 1'b1 >= cnt) ? FIRST_POS : p + 1'b1;
    endfunction

    // ****************************************
    // Sequencer
    // ****************************************
    seq_state_t state_r, state_nxt;
    logic [POS_W-1:0] pos_r, pos_nxt;
    logic dir_r, dir_nxt;
    logic done_r, done_nxt;
    logic start_r, start_nxt;
    logic stopReq_r, stopReq_nxt;
    logic discard_r, discard_nxt;
    logic [1:0] smode_r, smode_nxt;
    logic resumeRest_r, resumeRest_nxt;
    logic [WAIT_W-1:0] wait_r, wait_nxt;
    logic cyc, diMode;

    assign cyc = (runModeSelect == MODE_CYCLIC);
    assign diMode = (runModeSelect == MODE_DI);

    always_comb begin
        state_nxt = state_r;
        pos_nxt = pos_r;
        dir_nxt = dir_r;
        done_nxt = done_r;
        start_nxt = 1'b0;
        stopReq_nxt = stopReq_r;
        discard_nxt = discard_r;
        smode_nxt = smode_r;
        resumeRest_nxt = resumeRest_r;
        wait_nxt = wait_r;
        case (state_r)
            ST_IDLE: begin
                stopReq_nxt = 1'b0;
                discard_nxt = 1'b0;
                if (sonS && enS && (cyc || (diMode && diSteady))) begin
                    pos_nxt = diMode ? diS : FIRST_POS;     // [R9] [R10]
                    dir_nxt = dirS;                          // [R8]
                    start_nxt = 1'b1;
                    done_nxt = 1'b0;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!sonS) begin
                    stopReq_nxt = 1'b1;                      // [R6]
                    smode_nxt = stopModeSelect;              // [R6]
                    done_nxt = 1'b0;
                    state_nxt = ST_SOFF;
                end else if (cyc && !enS) begin
                    stopReq_nxt = 1'b1;                      // [R3]
                    discard_nxt = 1'b1;                      // [R3]
                    resumeRest_nxt = (marginMethod == MARGIN_FINISH);
                    state_nxt = ST_PAUSE;
                end else if (diMode && diS != pos_r && enS && diSteady) begin
                    pos_nxt = diS;                           // [R14]
                    dir_nxt = dirS;                          // [R8]
                    start_nxt = 1'b1;
                end else if (moveDone) begin
                    done_nxt = 1'b1;                         // [R2]
                    if (cyc) begin
                        pos_nxt = nextPos(pos_r, positionCountSetting);
                        wait_nxt = waitCycles;               // [R13]
                        state_nxt = ST_WAIT;                 // [R1] [R12]
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                if (!sonS) begin
                    done_nxt = 1'b0;                         // [R7]
                    state_nxt = ST_IDLE;
                end else if (!enS) begin
                    resumeRest_nxt = (marginMethod == MARGIN_FINISH);
                    state_nxt = ST_PAUSE;
                end else if (wait_r == '0) begin
                    dir_nxt = dirS;                          // [R8]
                    start_nxt = 1'b1;
                    done_nxt = 1'b0;
                    state_nxt = ST_RUN;
                end else begin
                    wait_nxt = wait_r - 1'b1;                // [R13]
                end
            end
            ST_PAUSE: begin
                if (stopReq_r && stopDone) begin
                    stopReq_nxt = 1'b0;
                    done_nxt = 1'b1;                         // [R4]
                end
                if (!sonS) begin
                    done_nxt = 1'b0;
                    stopReq_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end else if (!stopReq_r && enS) begin
                    if (!resumeRest_r)                       // [R5]
                        pos_nxt = FIRST_POS;
                    dir_nxt = dirS;
                    discard_nxt = 1'b0;
                    start_nxt = 1'b1;
                    done_nxt = 1'b0;
                    state_nxt = ST_RUN;
                end
            end
            ST_SOFF: begin
                done_nxt = 1'b0;                             // [R7]
                if (stopDone) begin
                    stopReq_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            pos_r <= FIRST_POS;
            dir_r <= 1'b0;
            done_r <= 1'b0;
            start_r <= 1'b0;
            stopReq_r <= 1'b0;
            discard_r <= 1'b0;
            smode_r <= 2'h0;
            resumeRest_r <= 1'b0;
            wait_r <= '0;
        end else begin
            state_r <= state_nxt;
            pos_r <= pos_nxt;
            dir_r <= dir_nxt;
            done_r <= done_nxt;
            start_r <= start_nxt;
            stopReq_r <= stopReq_nxt;
            discard_r <= discard_nxt;
            smode_r <= smode_nxt;
            resumeRest_r <= resumeRest_nxt;
            wait_r <= wait_nxt;
        end
    end

    assign posStart = start_r;
    assign posNumber = pos_r;
    assign posDirection = dir_r;
    assign stopRequest = stopReq_r;
    assign discardRemainder = discard_r;
    assign stopMode = smode_r;
    assign positioningComplete = done_r;

    // ****************************************
    // Checks
    // ****************************************
    property p_dirHold;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_RUN && !start_nxt && state_nxt == ST_RUN)
            |=> $stable(dir_r);
    endproperty
    a_dirHold: assert property (p_dirHold) // [R8]
        else $error("direction changed mid position");

    property p_doneOnMove;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_RUN && sonS && (enS || !cyc) && moveDone &&
         !(diMode && diS != pos_r)) |=> positioningComplete;
    endproperty
    a_doneOnMove: assert property (p_doneOnMove) // [R2]
        else $error("completion missing after move");

    property p_pauseStop;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_RUN && sonS && cyc && !enS)
            |=> (stopRequest && discardRemainder);
    endproperty
    a_pauseStop: assert property (p_pauseStop) // [R3]
        else $error("enable drop did not stop");

    property p_pauseDone;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_PAUSE && stopReq_r && stopDone && sonS)
            |=> positioningComplete;
    endproperty
    a_pauseDone: assert property (p_pauseDone) // [R4]
        else $error("completion missing after pause stop");

    property p_restart;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_PAUSE && !stopReq_r && enS && sonS &&
         marginMethod == MARGIN_RESTART)
            |=> (posStart && posNumber == FIRST_POS);
    endproperty
    a_restart: assert property (p_restart) // [R5]
        else $error("resume did not restart at first");

    property p_soff;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_RUN && !sonS)
            |=> (stopRequest && stopMode == $past(stopModeSelect));
    endproperty
    a_soff: assert property (p_soff) // [R6]
        else $error("servo off stop wrong");

    property p_soffLow;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_SOFF) |=> !positioningComplete;
    endproperty
    a_soffLow: assert property (p_soffLow) // [R7]
        else $error("completion high after servo off");

    property p_wrap;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_RUN && sonS && cyc && enS && moveDone &&
         pos_r + 1'b1 >= positionCountSetting)
            |=> (posNumber == FIRST_POS && state_r == ST_WAIT);
    endproperty
    a_wrap: assert property (p_wrap) // [R1] [R12]
        else $error("cycle did not wrap");

    property p_diTake;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_RUN && sonS && diMode && enS && diS != pos_r &&
         diSteady)
            |=> (posStart && posNumber == $past(diS));
    endproperty
    a_diTake: assert property (p_diTake) // [R9] [R10] [R14]
        else $error("DI position not taken");

    property p_wait;
        @(posedge mclk) disable iff (!reset_n)
        (state_r == ST_WAIT && wait_r != '0 && sonS && enS) |=> !posStart;
    endproperty
    a_wait: assert property (p_wait) // [R13]
        else $error("started during wait");
endmodule

// file: verif/motion_loop_model.sv
// Stand-in for the motion loop behind the sequencer.
// Assumes commands arrive on mclk; answers with fixed delays.
`timescale 1ns/1ps
module motion_loop_model #(
    parameter int MOVE_LAT = 8,
    parameter int STOP_LAT = 6
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Commands
    input wire logic posStart,
    input wire logic stopRequest,
    input wire logic hang,
    // Feedback
    output logic moveDone,
    output logic stopDone
);
    int moveCnt;
    int stopCnt;

    // ****************************************
    // Move and stop timers
    // ****************************************
    // Hang gives a move that never reports done, so only a stop can end it
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            moveCnt <= 0;
            stopCnt <= STOP_LAT;
            moveDone <= 1'b0;
            stopDone <= 1'b0;
        end else begin
            moveDone <= (moveCnt == 1);
            stopDone <= (stopCnt == 1);
            if (stopRequest)
                moveCnt <= 0;
            else if (posStart)
                moveCnt <= hang ? 0 : MOVE_LAT;
            else if (moveCnt > 0)
                moveCnt <= moveCnt - 1;
            if (!stopRequest)
                stopCnt <= STOP_LAT;
            else if (stopCnt > 0)
                stopCnt <= stopCnt - 1;
        end
    end
endmodule

// file: verif/multi_position_sequencer_test.sv
// Self-checking bench for the multi-position sequencer.
// Assumes the motion loop model answers moves and stops.
`timescale 1ns/1ps
module multi_position_sequencer_test;
    import mpos_pkg::*;
    logic mclk, reset_n, multiPositionEnable, servoOn, directionSelect;
    logic [POS_W-1:0] diPosition, positionCountSetting, posNumber;
    logic [1:0] runModeSelect, stopModeSelect, stopMode;
    logic marginMethod, moveDone, stopDone, hang;
    logic [WAIT_W-1:0] waitCycles;
    logic posStart, posDirection, stopRequest, discardRemainder;
    logic positioningComplete;
    int failCount, samplesChecked, n;

    multi_position_sequencer i_dut (
        .mclk(mclk), .reset_n(reset_n),
        .multiPositionEnable(multiPositionEnable), .servoOn(servoOn),
        .directionSelect(directionSelect), .diPosition(diPosition),
        .runModeSelect(runModeSelect), .marginMethod(marginMethod),
        .stopModeSelect(stopModeSelect),
        .positionCountSetting(positionCountSetting),
        .waitCycles(waitCycles), .moveDone(moveDone), .stopDone(stopDone),
        .posStart(posStart), .posNumber(posNumber),
        .posDirection(posDirection), .stopRequest(stopRequest),
        .discardRemainder(discardRemainder), .stopMode(stopMode),
        .positioningComplete(positioningComplete)
    );

    motion_loop_model i_loop (
        .mclk(mclk), .reset_n(reset_n), .posStart(posStart),
        .stopRequest(stopRequest), .hang(hang),
        .moveDone(moveDone), .stopDone(stopDone)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task finalReport;
        $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task check(input string name, input logic [15:0] seen,
               input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            failCount++;
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return posStart;
            1: return positioningComplete;
            default: return stopRequest;
        endcase
    endfunction

    // Always steps one edge first, so a pulse is never counted twice
    task automatic waitFor(input int k, input logic v, output int cnt);
        cnt = 0;
        do begin
            @(posedge mclk);
            #1;
            cnt++;
            if (cnt > 500) begin
                $display("Error timeout on signal %0d", k);
                failCount++;
                finalReport();
            end
        end while (pick(k) !== v);
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        failCount = 0;
        samplesChecked = 0;
        reset_n = 1'b0;
        multiPositionEnable = 1'b0;
        servoOn = 1'b1;
        directionSelect = 1'b1;
        diPosition = 4'h0;
        runModeSelect = MODE_CYCLIC;
        marginMethod = MARGIN_RESTART;
        stopModeSelect = 2'h2;
        positionCountSetting = 4'h2;
        waitCycles = 16'h0004;
        hang = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        multiPositionEnable = 1'b1;
        waitFor(0, 1'b1, n);
        check("posNumber", posNumber, 4'h0);
        check("posDirection", posDirection, 1'b1);
        directionSelect = 1'b0;
        waitFor(1, 1'b1, n);
        check("posDirection", posDirection, 1'b1);
        waitFor(0, 1'b1, n);
        check("waitGap", n > 4, 1'b1);
        check("posNumber", posNumber, 4'h1);
        check("posDirection", posDirection, 1'b0);
        waitFor(0, 1'b1, n);
        check("posNumber", posNumber, 4'h0);
        waitFor(0, 1'b1, n);
        hang = 1'b1;
        check("positioningComplete", positioningComplete, 1'b0);
        multiPositionEnable = 1'b0;
        waitFor(2, 1'b1, n);
        check("discardRemainder", discardRemainder, 1'b1);
        waitFor(1, 1'b1, n);
        check("stopRequest", stopRequest, 1'b0);
        multiPositionEnable = 1'b1;
        waitFor(0, 1'b1, n);
        check("posNumber", posNumber, 4'h0);
        servoOn = 1'b0;
        waitFor(2, 1'b1, n);
        check("stopMode", stopMode, 2'h2);
        waitFor(2, 1'b0, n);
        repeat (4) @(posedge mclk);
        #1;
        check("positioningComplete", positioningComplete, 1'b0);
        runModeSelect = MODE_DI;
        diPosition = 4'h5;
        servoOn = 1'b1;
        waitFor(0, 1'b1, n);
        check("posNumber", posNumber, 4'h5);
        diPosition = 4'h9;
        waitFor(0, 1'b1, n);
        check("posNumber", posNumber, 4'h9);
        check("stopRequest", stopRequest, 1'b0);
        runModeSelect = MODE_CYCLIC;
        marginMethod = MARGIN_FINISH;
        multiPositionEnable = 1'b0;
        waitFor(1, 1'b1, n);
        multiPositionEnable = 1'b1;
        waitFor(0, 1'b1, n);
        check("posNumber", posNumber, 4'h9);
        check("discardRemainder", discardRemainder, 1'b0);
        finalReport();
    end
endmodule
